/* File: hw/pd_evt_pkg.sv */
// Package: register map, field layout and types of the PD event and wake-up logic
package pd_evt_pkg;
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_FILTER = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
	localparam logic [11:0] OFS_CLEAR = 12'h010;
	localparam logic [11:0] OFS_RX_BYTE = 12'h014;
	localparam logic [11:0] OFS_TX_BYTE = 12'h018;
	localparam logic [11:0] OFS_LEVEL = 12'h01c;
	localparam int NUM_FLAGS = 16;
	localparam int FILTER_W = 9;
	localparam int BIT_WAKE_EN = 0;
	localparam int BIT_CARRIER = 1;
	localparam int BIT_STANDBY = 2;
	localparam int BIT_PULLDOWN = 3;
	localparam int FL_TX_REQ = 0;
	localparam int FL_TX_DISC = 1;
	localparam int FL_TX_SENT = 2;
	localparam int FL_TX_ABORT = 3;
	localparam int FL_HR_DISC = 4;
	localparam int FL_HR_SENT = 5;
	localparam int FL_UNDERRUN = 6;
	localparam int FL_ROLE_SWAP = 7;
	localparam int FL_RX_NE = 8;
	localparam int FL_ORDSET = 9;
	localparam int FL_HR_DET = 10;
	localparam int FL_OVERFLOW = 11;
	localparam int FL_RX_MSG = 12;
	localparam int FL_LVL_ONE = 14;
	localparam int FL_LVL_TWO = 15;
	localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 16'h0001;
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic [FILTER_W-1:0] FILTER_RST = 9'h000;
	localparam logic [NUM_FLAGS-1:0] IRQ_EN_RST = 16'h0000;
	localparam logic [31:0] CARRIER_PATTERN = 32'haaaa_aaaa;
	typedef struct packed {
		logic rx_done;
		logic rx_byte_valid;
		logic [7:0] rx_byte;
		logic [3:0] ordset_code;
		logic ordset_valid;
		logic hard_reset_rx;
		logic role_swap_rx;
		logic rx_busy;
		logic line_noise;
	} rx_evt_t;
	typedef struct packed {
		logic byte_needed;
		logic packet_done;
		logic start_req;
		logic hard_reset_req;
		logic hard_reset_done;
		logic hard_reset_fail;
		logic tx_busy;
	} tx_evt_t;
	typedef struct packed {
		logic [1:0] pin_one_voltage_state;
		logic [1:0] pin_two_voltage_state;
		logic thresh_one_act;
		logic thresh_two_act;
		logic biphase_act;
		logic role_swap_act;
	} level_t;
endpackage : pd_evt_pkg

/* File: hw/pd_phy_event_wakeup_logic.sv */
// PD PHY event flags, interrupt request, wake-up and clock request logic
// Function
// - Carrier test sends one repeating pattern without end until software stops it.
// - In stop modes level and role-swap detection keep running and wake; biphase activity only requests the kernel clock.
// - In standby nothing works, no wake-up; configured pull-downs stay applied. The transmit-request flag still follows the byte register here.
// - Stop-mode wake-up only while the wake enable bit is set.
// - A voltage range change on either pin is a wake-up event.
// - Received message wakes only if its ordered set is enabled in the filter.
// - With wake enabled, detector activity asserts the kernel clock request.
// - Set the role-swap flag on each new role-swap receive event.
// - Separate level flag per pin, set when its stable voltage state changes.
// - Set message-received flag when a complete message has been received.
// - Set overflow flag when a byte arrives while the previous is unread.
// - Set hard-reset-detected flag when hard reset signalling is received.
// - Set ordered-set flag when a new 4 K-code ordered set is recognised.
// - Receive-not-empty flag holds while the receive byte is unread.
// - Set underrun flag when a needed transmit byte was not written in time.
// - Each hard reset request ends in either a sent or a discarded flag.
// - Hard reset during transmission aborts the message and sets transmit-aborted.
// - Set message-sent flag when a complete packet has been transmitted.
// - Refuse transmission during reception or noise; set transmit-discarded.
// - Set transmit-request flag while the transmit byte register needs loading.
//
// The register addresses and the APB register port are this design's own decisions.
module pd_phy_event_wakeup_logic
	import pd_evt_pkg::*;
(
	input wire logic pclk, // APB clock, 40 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire rx_evt_t rx_evt, // Receiver events, same clock
	input wire tx_evt_t tx_evt, // Transmitter events, same clock
	input wire level_t level_pins, // Analog detector levels, asynchronous
	input wire logic stop_mode, // System is in a stop mode
	input wire logic standby_mode, // System is in standby
	output logic irq, // Level interrupt request
	output logic wakeup_req, // Wake-up request toward the system
	output logic kernel_clk_req, // Kernel clock request
	output logic tx_abort, // Abort current message for hard reset
	output logic tx_refuse, // Requested transmission refused
	output logic [31:0] tx_word, // Transmit byte or carrier pattern
	output logic carrier_active, // Carrier test pattern running
	output logic pulldown_on // Pull-down terminations applied
);
	logic [31:0] config_reg;
	logic [FILTER_W-1:0] ordered_set_filter_mask;
	logic [NUM_FLAGS-1:0] flags;
	logic [NUM_FLAGS-1:0] irq_en;
	logic [3:0] received_ordered_set_code;
	logic [7:0] receive_byte_register;
	logic [7:0] transmit_byte_register;
	logic tx_byte_full;
	level_t lvl_meta;
	level_t lvl_sync;
	level_t lvl_prev;
	logic wr_en;
	logic rd_en;
	logic hr_pending;
	logic [NUM_FLAGS-1:0] set_ev;
	logic [NUM_FLAGS-1:0] clr_ev;
	logic ordset_ok;
	logic level_change;
	logic active;
	logic [31:0] rd_word;
	logic rd_miss;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction : hit

	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && pready;
	// Standby kills every function but the pull-downs and the transmit-request flag; the rest reacts only outside it
	assign active = !config_reg[BIT_STANDBY] && !standby_mode;

	// Detector levels come from analog pins, so synchronise before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_meta <= '0;
			lvl_sync <= '0;
			lvl_prev <= '0;
		end else begin
			lvl_meta <= level_pins;
			lvl_sync <= lvl_meta;
			lvl_prev <= lvl_sync;
		end
	end

	assign level_change = (lvl_sync.pin_one_voltage_state != lvl_prev.pin_one_voltage_state)
		|| (lvl_sync.pin_two_voltage_state != lvl_prev.pin_two_voltage_state);
	assign ordset_ok = rx_evt.ordset_valid && rx_evt.ordset_code < 4'(FILTER_W)
		&& ordered_set_filter_mask[rx_evt.ordset_code];

	always_comb begin
		set_ev = '0;
		set_ev[FL_TX_REQ] = !tx_byte_full;
		set_ev[FL_TX_DISC] = tx_evt.start_req && (rx_evt.rx_busy || rx_evt.line_noise);
		set_ev[FL_TX_SENT] = tx_evt.packet_done;
		set_ev[FL_TX_ABORT] = tx_evt.hard_reset_req && tx_evt.tx_busy;
		set_ev[FL_HR_DISC] = hr_pending && tx_evt.hard_reset_fail;
		set_ev[FL_HR_SENT] = hr_pending && tx_evt.hard_reset_done && !tx_evt.hard_reset_fail;
		set_ev[FL_UNDERRUN] = tx_evt.byte_needed && !tx_byte_full;
		set_ev[FL_ROLE_SWAP] = rx_evt.role_swap_rx;
		set_ev[FL_RX_NE] = 1'b0;
		set_ev[FL_ORDSET] = rx_evt.ordset_valid;
		set_ev[FL_HR_DET] = rx_evt.hard_reset_rx;
		set_ev[FL_OVERFLOW] = rx_evt.rx_byte_valid && flags[FL_RX_NE];
		set_ev[FL_RX_MSG] = rx_evt.rx_done;
		set_ev[FL_LVL_ONE] = lvl_sync.pin_one_voltage_state
			!= lvl_prev.pin_one_voltage_state;
		set_ev[FL_LVL_TWO] = lvl_sync.pin_two_voltage_state
			!= lvl_prev.pin_two_voltage_state;
		if (!active) begin
			set_ev = '0;
		end
		clr_ev = '0;
		if (wr_en && hit(paddr, OFS_CLEAR)) begin
			clr_ev = pwdata[NUM_FLAGS-1:0];
		end
		clr_ev[FL_RX_NE] = 1'b0;
	end

	// Set wins over clear; receive-not-empty follows the byte register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= FLAGS_RST;
		end else begin
			flags <= (flags & ~clr_ev) | set_ev;
			flags[FL_TX_REQ] <= !tx_byte_full;
			if (rx_evt.rx_byte_valid && active) begin
				flags[FL_RX_NE] <= 1'b1;
			end else if (rd_en && hit(paddr, OFS_RX_BYTE)) begin
				flags[FL_RX_NE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_byte_register <= 8'h00;
			received_ordered_set_code <= 4'h0;
		end else begin
			if (rx_evt.rx_byte_valid && !flags[FL_RX_NE] && active) begin
				receive_byte_register <= rx_evt.rx_byte;
			end
			if (rx_evt.ordset_valid && active) begin
				received_ordered_set_code <= rx_evt.ordset_code;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_byte_register <= 8'h00;
			tx_byte_full <= 1'b0;
		end else begin
			if (wr_en && hit(paddr, OFS_TX_BYTE)) begin
				transmit_byte_register <= pwdata[7:0];
				tx_byte_full <= 1'b1;
			end else if (tx_evt.byte_needed) begin
				tx_byte_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hr_pending <= 1'b0;
		end else if (tx_evt.hard_reset_req && active) begin
			hr_pending <= 1'b1;
		end else if (tx_evt.hard_reset_done || tx_evt.hard_reset_fail) begin
			hr_pending <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= CONFIG_RST;
			ordered_set_filter_mask <= FILTER_RST;
			irq_en <= IRQ_EN_RST;
		end else if (wr_en) begin
			if (hit(paddr, OFS_CONFIG)) begin
				config_reg <= {28'h0000000, pwdata[3:0]};
			end
			if (hit(paddr, OFS_FILTER)) begin
				ordered_set_filter_mask <= pwdata[FILTER_W-1:0];
			end
			if (hit(paddr, OFS_IRQ_EN)) begin
				irq_en <= pwdata[NUM_FLAGS-1:0];
			end
		end
	end

	// Outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			wakeup_req <= 1'b0;
			kernel_clk_req <= 1'b0;
			tx_abort <= 1'b0;
			tx_refuse <= 1'b0;
			tx_word <= 32'h0000_0000;
			carrier_active <= 1'b0;
			pulldown_on <= 1'b0;
		end else begin
			irq <= active && |(flags & irq_en);
			wakeup_req <= active && stop_mode && config_reg[BIT_WAKE_EN]
				&& (level_change || (rx_evt.rx_done && ordset_ok)
				|| rx_evt.role_swap_rx);
			kernel_clk_req <= active && config_reg[BIT_WAKE_EN]
				&& (lvl_sync.thresh_one_act || lvl_sync.thresh_two_act
				|| lvl_sync.biphase_act || lvl_sync.role_swap_act);
			tx_abort <= active && tx_evt.hard_reset_req && tx_evt.tx_busy;
			tx_refuse <= set_ev[FL_TX_DISC];
			carrier_active <= active && config_reg[BIT_CARRIER];
			tx_word <= (active && config_reg[BIT_CARRIER]) ? CARRIER_PATTERN
				: {24'h000000, transmit_byte_register};
			pulldown_on <= config_reg[BIT_PULLDOWN];
		end
	end

	// Read word and unmapped flag decoded from the address alone
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_miss = 1'b0;
		case (paddr)
			OFS_CONFIG: rd_word = config_reg;
			OFS_FILTER: rd_word = {23'h000000, ordered_set_filter_mask};
			OFS_STATUS: rd_word = {16'h0000, flags};
			OFS_IRQ_EN: rd_word = {16'h0000, irq_en};
			OFS_CLEAR: rd_word = 32'h0000_0000;
			OFS_RX_BYTE: rd_word = {24'h000000, receive_byte_register};
			OFS_TX_BYTE: rd_word = {24'h000000, transmit_byte_register};
			OFS_LEVEL: rd_word = {24'h000000, received_ordered_set_code,
				lvl_sync.pin_two_voltage_state, lvl_sync.pin_one_voltage_state};
			default: rd_miss = 1'b1;
		endcase
	end

	// The setup edge registers the answer, so the access cycle needs no wait
	// and every bus output still comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && rd_miss;
			prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	sequence seq_wake_armed;
		active && stop_mode && config_reg[BIT_WAKE_EN];
	endsequence
	sequence seq_hr_ok;
		active && hr_pending && tx_evt.hard_reset_done && !tx_evt.hard_reset_fail;
	endsequence
	sequence seq_hr_bad;
		active && hr_pending && tx_evt.hard_reset_fail;
	endsequence

	AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		tx_evt.hard_reset_req && tx_evt.tx_busy && active |=> flags[FL_TX_ABORT] && tx_abort)
		else $error("abort flag missing");
	AST_WAKE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		!config_reg[BIT_WAKE_EN] |=> !wakeup_req && !kernel_clk_req)
		else $error("wake without enable");
	AST_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
		standby_mode |=> !wakeup_req)
		else $error("wake in standby");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		active && |(flags & irq_en) |=> irq)
		else $error("irq not raised");
	AST_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.rx_byte_valid && flags[FL_RX_NE] |=> flags[FL_OVERFLOW])
		else $error("overflow lost");
	AST_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
		active && tx_evt.start_req && rx_evt.rx_busy |=> flags[FL_TX_DISC] && tx_refuse)
		else $error("discard lost");
	AST_SENT: assert property (@(posedge pclk) disable iff (!presetn)
		active && tx_evt.packet_done |=> flags[FL_TX_SENT])
		else $error("sent flag lost");
	AST_RXNE: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.rx_byte_valid |=> flags[FL_RX_NE])
		else $error("not-empty lost");
	// Only a read of the byte register may empty it; a clear write must not
	AST_RXNE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		flags[FL_RX_NE] && !(rd_en && hit(paddr, OFS_RX_BYTE)) |=> flags[FL_RX_NE])
		else $error("not-empty dropped");
	AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("no ready in access");
	AST_TXREQ: assert property (@(posedge pclk) disable iff (!presetn)
		!tx_byte_full |=> flags[FL_TX_REQ])
		else $error("tx request missing");
	AST_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
		active && tx_evt.byte_needed && !tx_byte_full |=> flags[FL_UNDERRUN])
		else $error("underrun lost");
	AST_ROLE_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.role_swap_rx |=> flags[FL_ROLE_SWAP])
		else $error("role swap flag lost");
	AST_RX_MSG: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.rx_done |=> flags[FL_RX_MSG])
		else $error("message flag lost");
	AST_HR_DET: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.hard_reset_rx |=> flags[FL_HR_DET])
		else $error("hard reset detect lost");
	AST_ORDSET: assert property (@(posedge pclk) disable iff (!presetn)
		active && rx_evt.ordset_valid
		|=> flags[FL_ORDSET] && received_ordered_set_code == $past(rx_evt.ordset_code))
		else $error("ordered set lost");
	AST_LVL_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		active && lvl_sync.pin_one_voltage_state != lvl_prev.pin_one_voltage_state
		|=> flags[FL_LVL_ONE])
		else $error("pin one level lost");
	AST_LVL_TWO: assert property (@(posedge pclk) disable iff (!presetn)
		active && lvl_sync.pin_two_voltage_state != lvl_prev.pin_two_voltage_state
		|=> flags[FL_LVL_TWO])
		else $error("pin two level lost");
	AST_HR_PEND: assert property (@(posedge pclk) disable iff (!presetn)
		active && tx_evt.hard_reset_req |=> hr_pending)
		else $error("hard reset not pending");
	AST_HR_SENT: assert property (@(posedge pclk) disable iff (!presetn)
		seq_hr_ok |=> flags[FL_HR_SENT])
		else $error("hard reset sent lost");
	AST_HR_DISC: assert property (@(posedge pclk) disable iff (!presetn)
		seq_hr_bad |=> flags[FL_HR_DISC])
		else $error("hard reset discard lost");
	// Wake-up paths, each only while armed in a stop mode
	AST_WAKE_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		seq_wake_armed ##0 level_change |=> wakeup_req)
		else $error("level wake lost");
	AST_WAKE_MSG: assert property (@(posedge pclk) disable iff (!presetn)
		seq_wake_armed ##0 (rx_evt.rx_done && ordset_ok) |=> wakeup_req)
		else $error("message wake lost");
	AST_WAKE_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
		seq_wake_armed ##0 rx_evt.role_swap_rx |=> wakeup_req)
		else $error("role swap wake lost");
	AST_CLK_REQ: assert property (@(posedge pclk) disable iff (!presetn)
		active && config_reg[BIT_WAKE_EN] && (lvl_sync.thresh_one_act
		|| lvl_sync.thresh_two_act || lvl_sync.biphase_act || lvl_sync.role_swap_act)
		|=> kernel_clk_req)
		else $error("clock request lost");
	AST_CARRIER: assert property (@(posedge pclk) disable iff (!presetn)
		active && config_reg[BIT_CARRIER] |=> carrier_active && tx_word == CARRIER_PATTERN)
		else $error("carrier pattern lost");
	AST_PULLDOWN: assert property (@(posedge pclk) disable iff (!presetn)
		config_reg[BIT_PULLDOWN] |=> pulldown_on)
		else $error("pull-down dropped");
endmodule : pd_phy_event_wakeup_logic

/* File: verification/pd_phy_event_wakeup_logic_tb.sv */
// Self-checking bench of the PD event, interrupt and wake-up logic
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module pd_phy_event_wakeup_logic_tb import pd_evt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		rx_evt_t r;
		tx_evt_t t;
		logic [3:0] f;
	} row_t;
	row_t rows[8];
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic stop_mode = 0, standby_mode = 0, err, ab, rf;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q, tx_word;
	logic pready, pslverr, irq, wakeup_req, kernel_clk_req, tx_abort, tx_refuse;
	logic carrier_active, pulldown_on;
	rx_evt_t rx_evt = '0;
	tx_evt_t tx_evt = '0;
	level_t level_pins = '0;
	int failures = 0, checked = 0, w, k;
	always #12.5 pclk = ~pclk;
	pd_phy_event_wakeup_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .tx_evt(tx_evt),
		.level_pins(level_pins), .stop_mode(stop_mode), .standby_mode(standby_mode),
		.irq(irq), .wakeup_req(wakeup_req), .kernel_clk_req(kernel_clk_req),
		.tx_abort(tx_abort), .tx_refuse(tx_refuse), .tx_word(tx_word),
		.carrier_active(carrier_active), .pulldown_on(pulldown_on));
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// Read data and error are taken before the edge's own updates land
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
		@(posedge pclk);
	endtask : apb
	task automatic pulse(input rx_evt_t r, input tx_evt_t t);
		rx_evt <= r;
		tx_evt <= t;
		@(posedge pclk);
		rx_evt <= '0;
		tx_evt <= '0;
		@(posedge pclk);
		ab = tx_abort;
		rf = tx_refuse;
		w = int'(wakeup_req === 1'b1);
	endtask : pulse
	task automatic watch;
		w = 0;
		k = 0;
		repeat (12) begin
			@(posedge pclk);
			w += int'(wakeup_req === 1'b1);
			k += int'(kernel_clk_req === 1'b1);
		end
	endtask : watch
	task automatic flag(input int f, input logic e);
		apb(1'b0, OFS_STATUS, '0);
		`CHK(q[f], e)
	endtask : flag
	initial begin
		rows[0] = '{r: '{role_swap_rx: 1, default: 0}, t: 0, f: 7};
		rows[1] = '{r: '{rx_done: 1, default: 0}, t: 0, f: 12};
		rows[2] = '{r: '{hard_reset_rx: 1, default: 0}, t: 0, f: 10};
		rows[3] = '{r: '{ordset_valid: 1, default: 0}, t: 0, f: 9};
		rows[4] = '{r: 0, t: '{byte_needed: 1, default: 0}, f: 6};
		rows[5] = '{r: 0, t: '{packet_done: 1, default: 0}, f: 2};
		rows[6] = '{r: '{rx_busy: 1, default: 0}, t: '{start_req: 1, default: 0}, f: 1};
		rows[7] = '{r: '{line_noise: 1, default: 0}, t: '{start_req: 1, default: 0}, f: 1};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_STATUS, '0);
		`CHK(q[15:0], FLAGS_RST)
		// Flags are cleared after each row so rows stay independent
		foreach (rows[i]) begin
			pulse(rows[i].r, rows[i].t);
			if (rows[i].t.start_req) `CHK(rf, 1'b1)
			flag(rows[i].f, 1'b1);
			apb(1'b1, OFS_CLEAR, 32'h0000_ffff);
			flag(rows[i].f, 1'b0);
		end
		apb(1'b0, 12'h020, '0);
		`CHK({err, q}, 33'h1_0000_0000)
		apb(1'b1, OFS_TX_BYTE, 32'h0000_00a5);
		flag(FL_TX_REQ, 1'b0);
		pulse('0, '{byte_needed: 1, default: 0});
		flag(FL_TX_REQ, 1'b1);
		flag(FL_UNDERRUN, 1'b0);
		pulse('{rx_byte_valid: 1, rx_byte: 8'h5a, default: 0}, '0);
		flag(FL_RX_NE, 1'b1);
		pulse('{rx_byte_valid: 1, rx_byte: 8'h3c, default: 0}, '0);
		flag(FL_OVERFLOW, 1'b1);
		apb(1'b0, OFS_RX_BYTE, '0);
		`CHK(q[7:0], 8'h5a)
		flag(FL_RX_NE, 1'b0);
		pulse('0, '{hard_reset_req: 1, tx_busy: 1, default: 0});
		`CHK(ab, 1'b1)
		flag(FL_TX_ABORT, 1'b1);
		pulse('0, '{hard_reset_done: 1, default: 0});
		flag(FL_HR_SENT, 1'b1);
		pulse('0, '{hard_reset_req: 1, default: 0});
		pulse('0, '{hard_reset_fail: 1, default: 0});
		flag(FL_HR_DISC, 1'b1);
		apb(1'b1, OFS_CONFIG, 32'h0000_0001);
		apb(1'b1, OFS_FILTER, 32'h0000_0008);
		stop_mode <= 1'b1;
		level_pins <= '{pin_one_voltage_state: 2'h2, thresh_one_act: 1, default: 0};
		watch();
		`CHK({w > 0, k > 0}, 2'b11)
		flag(FL_LVL_ONE, 1'b1);
		flag(FL_LVL_TWO, 1'b0);
		pulse('{rx_done: 1, ordset_valid: 1, ordset_code: 4'h3, default: 0}, '0);
		`CHK(w, 1)
		pulse('{rx_done: 1, ordset_valid: 1, ordset_code: 4'h4, default: 0}, '0);
		`CHK(w, 0)
		apb(1'b0, OFS_LEVEL, '0);
		`CHK(q[7:0], 8'h42)
		pulse('{role_swap_rx: 1, default: 0}, '0);
		`CHK(w, 1)
		apb(1'b1, OFS_CONFIG, 32'h0000_0000);
		level_pins <= '{pin_one_voltage_state: 2'h2, pin_two_voltage_state: 2'h1,
			thresh_one_act: 1, default: 0};
		watch();
		`CHK({w, k}, 64'h0)
		flag(FL_LVL_TWO, 1'b1);
		apb(1'b1, OFS_CONFIG, 32'h0000_0009);
		standby_mode <= 1'b1;
		pulse('{role_swap_rx: 1, default: 0}, '0);
		`CHK({w, pulldown_on}, 33'h1)
		standby_mode <= 1'b0;
		apb(1'b1, OFS_CLEAR, 32'h0000_ffff);
		apb(1'b1, OFS_IRQ_EN, 32'h0000_0080);
		`CHK(irq, 1'b0)
		pulse('{role_swap_rx: 1, default: 0}, '0);
		flag(7, 1'b1);
		`CHK(irq, 1'b1)
		apb(1'b1, OFS_CLEAR, 32'h0000_0080);
		@(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, OFS_CONFIG, 32'h0000_0002);
		repeat (20) @(posedge pclk);
		`CHK({carrier_active, tx_word}, {1'b1, CARRIER_PATTERN})
		apb(1'b1, OFS_CONFIG, 32'h0000_0000);
		@(posedge pclk);
		`CHK(carrier_active, 1'b0)
		tally_and_finish();
	end
endmodule : pd_phy_event_wakeup_logic_tb
